// ---- core/tccp_core.sv ----
// two-channel capture/compare/pwm counter module with apb register access
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// ========================================
module tccp_core #(
    parameter int CNT_W = 16 // counter width
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  chan_pin_in,  // channel0_pin, channel1_pin input levels
    output logic      [1:0]  chan_pin_out, // driven pin levels
    output logic      [1:0]  chan_pin_oe,  // high while the channel drives its pin
    output logic      [1:0]  chan_irq      // per-channel interrupt requests
);
    // elaboration guard: the register map and the compare path carry a
    // 16-bit counter only, so any other width is refused up front
    if (CNT_W != 16) begin : g_bad_width
        $error("tccp_core supports only a 16-bit counter");
    end

    // ========================================
    // state
    logic [15:0]          count;        // shared up-counter
    logic [15:0]          period;       // period_limit_pair
    logic                 halt;         // counter_halt
    logic                 wrap_flag;    // counter_wrap_flag
    tccp_pkg::tccp_ctrl_s ctrl [2];     // channel_control_status
    logic [15:0]          value [2];    // channel_value_pair
    logic [1:0]           pin_prev;     // last sampled pin level for edge detection
    logic                 ch1_active;   // paired mode: channel 1 value in control
    logic                 ch1_pending;  // paired mode: channel 1 written since last hand-over
    logic                 ch0_pending;  // paired mode: channel 0 written since last hand-over

    // apb strobes: the write lands at the access edge
    logic wr_en;
    logic rd_en;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    logic wrap;       // counter at modulo value this tick
    logic paired;     // channels linked for buffered operation
    logic clear_cnt;  // software counter clear
    assign wrap      = ~halt & (count == period);
    assign paired    = ctrl[0].mode_select[1];
    assign clear_cnt = wr_en & (paddr == tccp_pkg::OFF_MODULE_CTRL) & pwdata[tccp_pkg::MC_CLEAR];

    // value the counter takes at this edge while running; compares act as the counter
    // reaches its value, so the pulse from wrap to match lasts exactly
    // value counts and duty equals value over the period count
    // limitation: a compare value of zero meets the wrap, and the wrap wins
    logic [15:0] next_count;
    always_comb begin
        next_count = count + 16'h0001;
        if (clear_cnt || wrap) begin
            next_count = 16'h0000; // restart, as the counter itself does
        end
    end

    // ========================================
    // counter: wraps to zero after the modulo value, so n gives n+1 counts
    // the clear bit restarts the count but leaves the period and flag alone
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= 16'h0000;
        end else if (clear_cnt) begin
            count <= 16'h0000;
        end else if (wrap) begin
            count <= 16'h0000;
        end else if (!halt) begin
            count <= count + 16'h0001;
        end
    end

    // module control and period registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            halt      <= tccp_pkg::HALT_RESET;
            period    <= tccp_pkg::PERIOD_RESET;
            wrap_flag <= 1'b0;
        end else begin
            if (wr_en && paddr == tccp_pkg::OFF_MODULE_CTRL) begin
                halt <= pwdata[tccp_pkg::MC_HALT];
            end
            if (wr_en && paddr == tccp_pkg::OFF_PERIOD) begin
                period <= pwdata[15:0];
            end
            // set wins over a software clear in the same cycle
            if (wrap) begin
                wrap_flag <= 1'b1;
            end else if (wr_en && paddr == tccp_pkg::OFF_MODULE_CTRL
                         && !pwdata[tccp_pkg::MC_WRAP_FLAG]) begin
                wrap_flag <= 1'b0;
            end
        end
    end

    // ========================================
    // per-channel decode
    logic [1:0]  is_capture;  // mode 00: input capture
    logic [1:0]  edge_hit;    // selected edge seen on pin
    logic [1:0]  match;       // next counter value equals active compare value
    logic [1:0]  ch_event;    // capture or compare event this tick
    logic [1:0]  ctrl_wr;     // control register written
    logic [1:0]  val_wr;      // value register written
    logic [15:0] cmp_val [2]; // value actually compared
    logic [1:0]  pin_enabled; // channel owns its pin

    assign cmp_val[0] = (paired && ch1_active) ? value[1] : value[0];
    assign cmp_val[1] = value[1];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_dec
            logic rise;
            logic fall;
            assign rise = ~pin_prev[gi] & chan_pin_in[gi];
            assign fall = pin_prev[gi] & ~chan_pin_in[gi];
            // channel 1 is idle while paired
            assign pin_enabled[gi] = (gi == 0) ? (ctrl[0].mode_select != 2'b00
                                     || ctrl[0].edge_level_select != 2'b00)
                                   : (!paired && (ctrl[1].mode_select != 2'b00
                                     || ctrl[1].edge_level_select != 2'b00));
            assign is_capture[gi] = (ctrl[gi].mode_select == 2'b00) && !(gi == 1 && paired);
            // els 01 rising, 10 falling, 11 either edge
            assign edge_hit[gi] = (ctrl[gi].edge_level_select[0] & rise)
                                | (ctrl[gi].edge_level_select[1] & fall);
            // match on the live value: a skipped-over new value gives no match
            // until the counter comes round to it in the next period
            assign match[gi] = ~halt & ~is_capture[gi] & pin_enabled[gi]
                             & (next_count == cmp_val[gi]);
            assign ch_event[gi] = (is_capture[gi] & edge_hit[gi]) | match[gi];
            assign ctrl_wr[gi] = wr_en && paddr == ((gi == 0) ? tccp_pkg::OFF_CH0_CTRL
                                                             : tccp_pkg::OFF_CH1_CTRL);
            assign val_wr[gi] = wr_en && paddr == ((gi == 0) ? tccp_pkg::OFF_CH0_VALUE
                                                            : tccp_pkg::OFF_CH1_VALUE);
        end
    endgenerate

    // ========================================
    // channel control, values and capture latch
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    ctrl[gi]     <= tccp_pkg::tccp_ctrl_s'(tccp_pkg::CTRL_RESET);
                    value[gi]    <= 16'h0000;
                    pin_prev[gi] <= 1'b0;
                end else begin
                    pin_prev[gi] <= chan_pin_in[gi];
                    if (ctrl_wr[gi]) begin
                        ctrl[gi].irq_enable        <= pwdata[tccp_pkg::CC_IRQ_EN];
                        ctrl[gi].mode_select[1]    <= (gi == 0) ? pwdata[tccp_pkg::CC_MS_B]
                                                                : 1'b0;
                        ctrl[gi].mode_select[0]    <= pwdata[tccp_pkg::CC_MS_A];
                        ctrl[gi].edge_level_select <= pwdata[tccp_pkg::CC_ELS_B:
                                                             tccp_pkg::CC_ELS_A];
                        ctrl[gi].toggle_at_wrap    <= pwdata[tccp_pkg::CC_TOGGLE];
                        ctrl[gi].full_duty_force   <= pwdata[tccp_pkg::CC_FULL_DUTY];
                    end
                    // flag: event sets and wins over a zero written the same cycle
                    if (ch_event[gi]) begin
                        ctrl[gi].event_flag <= 1'b1;
                    end else if (ctrl_wr[gi] && !pwdata[tccp_pkg::CC_EVENT_FLAG]) begin
                        ctrl[gi].event_flag <= 1'b0;
                    end
                    // capture wins over a software write of the value
                    if (is_capture[gi] && edge_hit[gi]) begin
                        value[gi] <= count;
                    end else if (val_wr[gi]) begin
                        value[gi] <= pwdata[15:0];
                    end
                end
            end
        end
    endgenerate

    // ========================================
    // paired hand-over: the last written register takes control at wrap, but a channel 0 write in the wrap cycle yields to a pending channel 1
    // a write to the register in control acts at once, as unbuffered, so
    // software is expected to write only the idle one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ch1_active  <= 1'b0;
            ch1_pending <= 1'b0;
            ch0_pending <= 1'b0;
        end else if (!paired) begin
            ch1_active  <= 1'b0; // channel 0 controls first when pairing starts
            ch1_pending <= 1'b0;
            ch0_pending <= 1'b0;
        end else begin
            if (wrap) begin
                if (ch1_pending || val_wr[1]) begin
                    ch1_active <= 1'b1;
                end else if (ch0_pending || val_wr[0]) begin
                    ch1_active <= 1'b0;
                end
                ch1_pending <= 1'b0;
                ch0_pending <= 1'b0;
            end else if (val_wr[1]) begin
                ch1_pending <= 1'b1;
                ch0_pending <= 1'b0;
            end else if (val_wr[0]) begin
                ch0_pending <= 1'b1;
                ch1_pending <= 1'b0;
            end
        end
    end

    // ========================================
    // pin actions: wrap toggle overrides a coinciding match
    // the pin level is registered state only, so a channel that hands its
    // pin back keeps its last level for the next time it drives
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    chan_pin_out[gi] <= 1'b0;
                    chan_pin_oe[gi]  <= 1'b0;
                    chan_irq[gi]     <= 1'b0;
                end else begin
                    chan_pin_oe[gi] <= pin_enabled[gi] && !is_capture[gi];
                    chan_irq[gi] <= ctrl[gi].event_flag & ctrl[gi].irq_enable;
                    if (ctrl[gi].full_duty_force && ctrl[gi].toggle_at_wrap
                        && !is_capture[gi] && pin_enabled[gi]) begin
                        chan_pin_out[gi] <= 1'b1;
                    end else if (wrap && ctrl[gi].toggle_at_wrap && !is_capture[gi]
                                 && pin_enabled[gi]) begin
                        chan_pin_out[gi] <= ~chan_pin_out[gi];
                    end else if (match[gi]) begin
                        // 10 clears, 11 sets, 01 toggles, 00 holds
                        unique case (ctrl[gi].edge_level_select)
                            2'b10: chan_pin_out[gi] <= 1'b0;
                            2'b11: chan_pin_out[gi] <= 1'b1;
                            2'b01: chan_pin_out[gi] <= ~chan_pin_out[gi];
                            2'b00: chan_pin_out[gi] <= chan_pin_out[gi];
                        endcase
                    end
                end
            end
        end
    endgenerate

    // ========================================
    // apb slave: zero wait states, unmapped offsets answer with an error
    // ready is a registered pulse, so the write strobe needs only psel and
    // penable: with no wait states the access edge is the ready edge
    logic        mapped;
    logic [31:0] rd_mux;
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            tccp_pkg::OFF_MODULE_CTRL: begin
                rd_mux[tccp_pkg::MC_WRAP_FLAG] = wrap_flag;
                rd_mux[tccp_pkg::MC_HALT]      = halt;
            end
            tccp_pkg::OFF_COUNT:     rd_mux[15:0] = count;
            tccp_pkg::OFF_PERIOD:    rd_mux[15:0] = period;
            tccp_pkg::OFF_CH0_CTRL:  rd_mux[7:0]  = ctrl[0];
            tccp_pkg::OFF_CH0_VALUE: rd_mux[15:0] = value[0];
            tccp_pkg::OFF_CH1_CTRL:  rd_mux[7:0]  = ctrl[1];
            tccp_pkg::OFF_CH1_VALUE: rd_mux[15:0] = value[1];
            default:                 mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // ready one cycle after setup, dropped after the access edge
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // ========================================
    // assertions
    a_wrap_restarts: assert property (@(posedge clk) disable iff (sys_rst)
        (wrap && !clear_cnt) |=> (count == 16'h0000 && wrap_flag))
        else $error("counter did not restart at zero after wrap");
    // channel 1 carries the capture traffic of the scenarios
    a_capture_latch: assert property (@(posedge clk) disable iff (sys_rst)
        (is_capture[1] && edge_hit[1]) |=> (value[1] == $past(count)))
        else $error("capture did not latch counter");
    a_flag_sets: assert property (@(posedge clk) disable iff (sys_rst)
        ch_event[1] |=> ctrl[1].event_flag)
        else $error("event flag not set");
    a_irq_gated: assert property (@(posedge clk) disable iff (sys_rst)
        chan_irq[0] |-> $past(ctrl[0].irq_enable && ctrl[0].event_flag))
        else $error("irq without enabled flag");
    a_match_clears: assert property (@(posedge clk) disable iff (sys_rst)
        (match[0] && !wrap && !ctrl[0].full_duty_force
         && ctrl[0].edge_level_select == 2'b10) |=> !chan_pin_out[0])
        else $error("clear on match failed");
    a_wrap_toggle: assert property (@(posedge clk) disable iff (sys_rst)
        (wrap && ctrl[1].toggle_at_wrap && !ctrl[1].full_duty_force && pin_enabled[1]
         && !is_capture[1]) |=> (chan_pin_out[1] != $past(chan_pin_out[1])))
        else $error("pin did not toggle at wrap");
    a_full_duty: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl[0].full_duty_force && ctrl[0].toggle_at_wrap && pin_enabled[0]
         && !is_capture[0]) |=> chan_pin_out[0])
        else $error("full duty not high");
    a_pair_frees: assert property (@(posedge clk) disable iff (sys_rst)
        paired ##1 paired |-> !chan_pin_oe[1])
        else $error("channel 1 pin driven while paired");
    a_ready_one: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && !penable) |=> pready) // zero wait state answer
        else $error("apb answer late");

    // ========================================
    // guards on counting, capture, compare and the bus
    // hazard: a halted counter that creeps would shift every capture stamp
    a_halt_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (halt && !clear_cnt) |=> $stable(count)) // counter frozen while halted
        else $error("counter moved while halted");
    a_clear_restarts: assert property (@(posedge clk) disable iff (sys_rst)
        clear_cnt |=> (count == 16'h0000)) // software restart
        else $error("counter clear did not restart at zero");
    a_capture_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        is_capture[0] |=> !chan_pin_oe[0])
        else $error("capture channel drives its pin");
    a_irq_follows: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl[1].event_flag && ctrl[1].irq_enable) |=> chan_irq[1])
        else $error("enabled flag raised no irq");
    a_match_sets: assert property (@(posedge clk) disable iff (sys_rst)
        (match[0] && !wrap && ctrl[0].edge_level_select == 2'b11)
        |=> chan_pin_out[0])
        else $error("set on match failed");
    // the slave answers each setup with a single ready cycle
    a_ready_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        pready |=> !pready) // one-cycle answer
        else $error("apb ready held too long");
    a_err_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && !penable && !mapped) |=> pslverr) // refused offset
        else $error("unmapped offset not refused");
endmodule
`default_nettype wire

// ---- shared/tccp_pkg.sv ----
// package for the two-channel capture/compare/pwm counter module
package tccp_pkg;
    // ========================================
    // register byte offsets on the apb bus
    localparam logic [7:0] OFF_MODULE_CTRL = 8'h00; // halt, counter clear, wrap flag
    localparam logic [7:0] OFF_COUNT       = 8'h04; // counter value, read only
    localparam logic [7:0] OFF_PERIOD      = 8'h08; // period_limit_pair
    localparam logic [7:0] OFF_CH0_CTRL    = 8'h0c; // channel0_control_status
    localparam logic [7:0] OFF_CH0_VALUE   = 8'h10; // channel 0 channel_value_pair
    localparam logic [7:0] OFF_CH1_CTRL    = 8'h14; // channel1_control_status
    localparam logic [7:0] OFF_CH1_VALUE   = 8'h18; // channel 1 channel_value_pair
    // ========================================
    // module control field positions
    localparam int MC_WRAP_FLAG = 7;
    localparam int MC_HALT      = 5;
    localparam int MC_CLEAR     = 4;
    // channel control field positions
    localparam int CC_EVENT_FLAG = 7;
    localparam int CC_IRQ_EN     = 6;
    localparam int CC_MS_B       = 5;
    localparam int CC_MS_A       = 4;
    localparam int CC_ELS_B      = 3;
    localparam int CC_ELS_A      = 2;
    localparam int CC_TOGGLE     = 1;
    localparam int CC_FULL_DUTY  = 0;
    // ========================================
    // reset values
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic        HALT_RESET   = 1'b1;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    // ========================================
    // channel control word
    typedef struct packed {
        logic       event_flag;         // channel_event_flag
        logic       irq_enable;         // channel_irq_enable
        logic [1:0] mode_select;        // channel_mode_select
        logic [1:0] edge_level_select;  // edge_level_select
        logic       toggle_at_wrap;     // toggle_at_wrap
        logic       full_duty_force;    // full_duty_force
    } tccp_ctrl_s;
endpackage

// ---- testbench/tccp_pin_model.sv ----
// pin-side model: external event sources and loads on the two channel pins
`timescale 1ns/1ps
`default_nettype none
module tccp_pin_model (
    input  wire logic [1:0] src_level,    // level each external source drives
    input  wire logic [1:0] chan_pin_oe,  // device drive enables
    input  wire logic [1:0] chan_pin_out, // device drive levels
    output logic      [1:0] chan_pin_in   // resolved wire levels
);
    // ========================================
    // wire resolution
    // the device wins while it drives; the source is a weak load then, so
    // a stray source level cannot fight the compare output
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            chan_pin_in[i] = chan_pin_oe[i] ? chan_pin_out[i] : src_level[i];
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tccp_core_test.sv ----
// self-checking bench for the two-channel capture/compare/pwm counter module
`timescale 1ns/1ps
`default_nettype none
module tccp_core_test;
    // ========================================
    // signals
    logic        clk;       // 20 mhz clock
    logic        sys_rst;   // synchronous reset, active high
    logic        psel;      // apb select
    logic        penable;   // apb access phase
    logic        pwrite;    // apb direction
    logic [7:0]  paddr;     // apb byte offset
    logic [31:0] pwdata;    // apb write data
    logic [31:0] prdata;    // apb read data
    logic        pready;    // apb answer
    logic        pslverr;   // apb refusal
    logic [1:0]  pin_in;    // resolved pin levels
    logic [1:0]  pin_out;   // device pin drive
    logic [1:0]  pin_oe;    // device pin enables
    logic [1:0]  irq;       // channel interrupt requests
    logic [1:0]  src_level; // external source levels
    logic [31:0] rdat;      // last read word
    logic        rerr;      // last read refusal
    int          errors;    // mismatches seen
    int          cmp_count; // comparisons made
    int          cycles;    // timeout counter
    int          ones;      // high cycles in a duty window
    int          ones1;     // high cycles of the channel 1 pin in a window

    tccp_core tccp_core_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
        .chan_pin_oe(pin_oe), .chan_irq(irq));

    tccp_pin_model tccp_pin_model_inst (.src_level(src_level), .chan_pin_oe(pin_oe),
        .chan_pin_out(pin_out), .chan_pin_in(pin_in));

    // ========================================
    // clock and hang guard
    always #25 clk = ~clk;
    // a run far past the expected few hundred cycles means a stuck wait
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    // ========================================
    // shared tasks
    task automatic print_verdict();
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no wait count assumed: only the bench timeout ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    // high cycles of both channel pins over n consecutive cycles
    task automatic duty(input int n);
        ones = 0;
        ones1 = 0;
        repeat (n) begin
            @(posedge clk);
            if (pin_out[0] === 1'b1) ones++;
            if (pin_out[1] === 1'b1) ones1++;
        end
    endtask

    // software setup order: stop and clear, period, width, mode, then run
    task automatic pwm_setup(input logic [31:0] val, input logic [31:0] ctl);
        wr(tccp_pkg::OFF_MODULE_CTRL, 32'h30);
        wr(tccp_pkg::OFF_PERIOD, 32'h9);
        wr(tccp_pkg::OFF_CH0_VALUE, val);
        wr(tccp_pkg::OFF_CH1_VALUE, 32'h5); // channel 1 runs its own pwm unless paired
        wr(tccp_pkg::OFF_CH1_CTRL, 32'h1a);
        wr(tccp_pkg::OFF_CH0_CTRL, ctl);
        wr(tccp_pkg::OFF_MODULE_CTRL, 32'h0);
        repeat (30) @(posedge clk);
    endtask

    // ========================================
    // scenarios
    task automatic test_reset_map();
        rd(tccp_pkg::OFF_PERIOD);
        chk(rdat, 32'hffff);
        rd(tccp_pkg::OFF_MODULE_CTRL);
        chk(rdat, 32'h20);
        rd(8'h1c);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
    endtask

    task automatic test_capture();
        logic [31:0] cnt;
        wr(tccp_pkg::OFF_MODULE_CTRL, 32'h0);
        repeat (12) @(posedge clk);
        wr(tccp_pkg::OFF_MODULE_CTRL, 32'h20);
        rd(tccp_pkg::OFF_COUNT);
        cnt = rdat;
        chk(cnt, 32'hf);
        wr(tccp_pkg::OFF_CH1_CTRL, 32'h48); // falling edge, irq enabled
        src_level[1] <= 1'b1;
        repeat (5) @(posedge clk);
        rd(tccp_pkg::OFF_CH1_CTRL);
        chk(rdat, 32'h48);
        src_level[1] <= 1'b0;
        repeat (5) @(posedge clk);
        rd(tccp_pkg::OFF_CH1_CTRL);
        chk(rdat, 32'hc8);
        chk({30'h0, irq}, 32'h2);
        rd(tccp_pkg::OFF_CH1_VALUE);
        chk(rdat, cnt);
        wr(tccp_pkg::OFF_CH1_CTRL, 32'h08); // flag and irq cleared
        repeat (3) @(posedge clk);
        chk({30'h0, irq}, 32'h0);
    endtask

    task automatic test_compare();
        pwm_setup(32'h3, 32'h5c); // set on match, irq enabled
        chk({31'h0, pin_out[0]}, 32'h1);
        chk({31'h0, pin_oe[0]}, 32'h1);
        chk({31'h0, irq[0]}, 32'h1);
        rd(tccp_pkg::OFF_MODULE_CTRL);
        chk(rdat, 32'h80);
        wr(tccp_pkg::OFF_CH0_CTRL, 32'h18); // clear on match, no wrap toggle
        repeat (25) @(posedge clk);
        duty(10);
        chk(ones, 0);
    endtask

    task automatic test_pwm();
        pwm_setup(32'h4, 32'h1a);
        duty(10);
        chk(ones, 4);
        chk(ones1, 5);
        wr(tccp_pkg::OFF_CH0_CTRL, 32'h1b);
        repeat (25) @(posedge clk);
        duty(10);
        chk(ones, 10);
        wr(tccp_pkg::OFF_CH0_CTRL, 32'h1a);
        wr(tccp_pkg::OFF_CH0_VALUE, 32'h7);
        repeat (25) @(posedge clk);
        duty(10);
        chk(ones, 7);
    endtask

    task automatic test_paired();
        pwm_setup(32'h2, 32'h3a); // both mode bits set, buffered wins
        duty(10);
        chk(ones, 2);
        chk({31'h0, pin_oe[1]}, 32'h0);
        wr(tccp_pkg::OFF_CH1_VALUE, 32'h6);
        repeat (25) @(posedge clk);
        duty(10);
        chk(ones, 6);
        wr(tccp_pkg::OFF_CH0_VALUE, 32'h3);
        repeat (25) @(posedge clk);
        duty(10);
        chk(ones, 3);
    endtask

    // ========================================
    // main sequence
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        src_level = 2'b00;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        test_reset_map();
        test_capture();
        test_compare();
        test_pwm();
        test_paired();
        print_verdict();
    end
endmodule
`default_nettype wire
